// ==== rtccal_pkg.sv ====
// package for the calendar time registers: offsets, fields, reset values, types
// Function
// (R01) minutes register holds BCD minute 0..59 in bits 6..0, bit 7 reads zero
// (R02) hours bit 6 selects 12-hour mode; bit 5 is PM; hours 1..12 BCD
// (R03) in 24-hour mode hours bits 5..0 hold BCD 0..23, bit 7 reads zero
// (R04) host writes only valid in-range BCD hours matching the selected format
// (R05) day of month BCD 1..31; February has 29 days when year divisible by 4
// (R06) weekday bits 2..0 count 1..7 cyclically; meaning is up to the host
// (R07) month bits 4..0 count BCD 1..12; bits 7..5 read zero
// (R08) every unimplemented bit in these registers reads back as zero
package rtccal_pkg;
	localparam int unsigned ADDR_W          = 4;
	localparam logic [3:0]  OFS_MINUTES     = 4'h9;
	localparam logic [3:0]  OFS_HOURS       = 4'ha;
	localparam logic [3:0]  OFS_DAY         = 4'hb;
	localparam logic [3:0]  OFS_WEEKDAY     = 4'hc;
	localparam logic [3:0]  OFS_MONTH       = 4'hd;
	localparam logic [3:0]  OFS_SECOND_TICK = 4'h0;
	localparam logic [3:0]  OFS_YEAR        = 4'h1;
	localparam logic [7:0]  MASK_MINUTES    = 8'h7f;
	localparam logic [7:0]  MASK_HOURS      = 8'h7f;
	localparam logic [7:0]  MASK_DAY        = 8'h3f;
	localparam logic [7:0]  MASK_WEEKDAY    = 8'h07;
	localparam logic [7:0]  MASK_MONTH      = 8'h1f;
	localparam logic [7:0]  MASK_YEAR       = 8'h7f;
	localparam int unsigned HOUR_MODE_BIT   = 6;
	localparam int unsigned AFTERNOON_BIT   = 5;
	localparam logic [7:0]  RST_MINUTES     = 8'h00;
	localparam logic [7:0]  RST_HOURS       = 8'h00;
	localparam logic [7:0]  RST_DAY         = 8'h01;
	localparam logic [7:0]  RST_WEEKDAY     = 8'h01;
	localparam logic [7:0]  RST_MONTH       = 8'h01;
	localparam logic [7:0]  RST_YEAR        = 8'h00;
	localparam int unsigned CLOCK_HZ        = 40000000;
	localparam int unsigned SECOND_CYCLES   = CLOCK_HZ;

	typedef struct packed {
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] day;
		logic [7:0] weekday;
		logic [7:0] month;
	} rtccal_time_t;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [3:0] address;
		logic [7:0] writedata;
	} rtccal_req_t;
endpackage : rtccal_pkg

// ==== rtccal_tick.sv ====
// one-cycle enable pulse each second from the system clock
`timescale 1ns/100ps
module rtccal_tick #(
	parameter int unsigned CYCLES = rtccal_pkg::SECOND_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);
	import rtccal_pkg::*;
	logic [31:0] count_reg;
	wire         at_end = (count_reg == CYCLES - 1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 32'h0;
		end else if (!run || at_end) begin
			count_reg <= 32'h0;
		end else begin
			count_reg <= count_reg + 32'h1;
		end
	end

	assign tick = run && at_end;
endmodule : rtccal_tick

// ==== rtccal_next.sv ====
// combinational calendar advance by one minute
`timescale 1ns/100ps
module rtccal_next (
	input  rtccal_pkg::rtccal_time_t now,
	input  wire logic [7:0]          year,
	output rtccal_pkg::rtccal_time_t nxt
);
	import rtccal_pkg::*;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	wire        mode12   = now.hours[HOUR_MODE_BIT];
	wire        pm       = now.hours[AFTERNOON_BIT];
	wire [7:0]  h24      = now.hours & 8'h3f;
	wire [7:0]  h12      = now.hours & 8'h1f;
	wire        min_wrap = (now.minutes == 8'h59);
	wire        day_roll = min_wrap && (mode12 ? (h12 == 8'h11 && pm) : (h24 == 8'h23));
	// year bcd divisible by 4: tens even with units 0,4,8 or tens odd with 2,6
	wire        leap     = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
	                               : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
	wire [7:0]  last_day = (now.month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
	                       (now.month == 8'h04 || now.month == 8'h06 ||
	                        now.month == 8'h09 || now.month == 8'h11) ? 8'h30 : 8'h31;
	wire        mon_roll = day_roll && (now.day == last_day);
	wire [7:0]  hr12_inc = (h12 == 8'h12) ? 8'h01 : bcd_inc(h12);
	wire        pm_next  = (h12 == 8'h11) ? ~pm : pm;

	always_comb begin
		nxt         = now;
		nxt.minutes = min_wrap ? 8'h00 : bcd_inc(now.minutes); // see (R01)
		if (min_wrap) begin
			if (mode12) begin
				nxt.hours = {2'b01, pm_next, hr12_inc[4:0]}; // see (R02)
			end else begin
				nxt.hours = (h24 == 8'h23) ? 8'h00 : bcd_inc(h24); // see (R03)
			end
		end
		if (day_roll) begin
			nxt.weekday = (now.weekday == 8'h07) ? 8'h01 : now.weekday + 8'h01; // see (R06)
			nxt.day     = (now.day == last_day) ? 8'h01 : bcd_inc(now.day); // see (R05)
		end
		if (mon_roll) begin
			nxt.month = (now.month == 8'h12) ? 8'h01 : bcd_inc(now.month); // see (R07)
		end
	end
endmodule : rtccal_next

// ==== rtccal_top.sv ====
// calendar time registers with avalon-mm slave and minute carry
`timescale 1ns/100ps
module rtccal_top #(
	parameter int unsigned SECOND_CYCLES = rtccal_pkg::SECOND_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	output logic             minute_tick
);
	import rtccal_pkg::*;

	logic         rst_meta_reg;
	logic         rst_n_reg;
	rtccal_time_t time_reg;
	rtccal_time_t time_next;
	rtccal_time_t adv;
	logic [7:0]   year_reg;
	logic [7:0]   second_reg;
	logic [31:0]  readdata_reg;
	logic         ack_reg;
	logic         tick_1s;
	logic         minute_pulse_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	rtccal_tick #(.CYCLES(SECOND_CYCLES)) u_tick (
		.clock(clock),
		.rst_n(rst_n_reg),
		.run  (1'b1),
		.tick (tick_1s)
	);

	wire minute_carry = tick_1s && (second_reg == 8'h59);

	rtccal_next u_next (
		.now (time_reg),
		.year(year_reg),
		.nxt (adv)
	);

	// one wait state: waitrequest falls in the cycle after read/write rises
	wire       req      = (read || write) && !ack_reg;
	// a write lands at the edge where waitrequest is sampled low, never earlier
	wire       wr_go    = write && ack_reg && byteenable[0];
	wire [7:0] wbyte    = writedata[7:0];
	wire       wr_min   = wr_go && (address == OFS_MINUTES);
	wire       wr_hour  = wr_go && (address == OFS_HOURS);
	wire       wr_day   = wr_go && (address == OFS_DAY);
	wire       wr_wday  = wr_go && (address == OFS_WEEKDAY);
	wire       wr_mon   = wr_go && (address == OFS_MONTH);
	wire       wr_sec   = wr_go && (address == OFS_SECOND_TICK);
	wire       wr_year  = wr_go && (address == OFS_YEAR);
	wire       wr_any   = wr_min || wr_hour || wr_day || wr_wday || wr_mon;

	// host write wins over the advance for the field written; see (R04)
	always_comb begin
		time_next = minute_carry ? adv : time_reg;
		if (wr_min) begin
			time_next.minutes = wbyte & MASK_MINUTES; // see (R08)
		end
		if (wr_hour) begin
			time_next.hours = wbyte & MASK_HOURS; // see (R08)
		end
		if (wr_day) begin
			time_next.day = wbyte & MASK_DAY; // see (R08)
		end
		if (wr_wday) begin
			time_next.weekday = wbyte & MASK_WEEKDAY; // see (R08)
		end
		if (wr_mon) begin
			time_next.month = wbyte & MASK_MONTH; // see (R08)
		end
	end

	wire [7:0] rd_byte = (address == OFS_MINUTES)     ? time_reg.minutes :
	                     (address == OFS_HOURS)       ? time_reg.hours :
	                     (address == OFS_DAY)         ? time_reg.day :
	                     (address == OFS_WEEKDAY)     ? time_reg.weekday :
	                     (address == OFS_MONTH)       ? time_reg.month :
	                     (address == OFS_SECOND_TICK) ? second_reg :
	                     (address == OFS_YEAR)        ? year_reg : 8'h00;

	wire [7:0] sec_inc = (second_reg[3:0] == 4'h9) ? {second_reg[7:4] + 4'h1, 4'h0}
	                                               : {second_reg[7:4], second_reg[3:0] + 4'h1};

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			time_reg <= '{RST_MINUTES, RST_HOURS, RST_DAY, RST_WEEKDAY, RST_MONTH};
		end else begin
			time_reg <= time_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			second_reg <= 8'h00;
		end else if (wr_sec) begin
			second_reg <= wbyte & MASK_MINUTES;
		end else if (minute_carry) begin
			second_reg <= 8'h00;
		end else if (tick_1s) begin
			second_reg <= sec_inc;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			year_reg <= RST_YEAR;
		end else if (wr_year) begin
			year_reg <= wbyte & MASK_YEAR;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ack_reg          <= 1'b0;
			readdata_reg     <= 32'h0;
			minute_pulse_reg <= 1'b0;
		end else begin
			ack_reg          <= req;
			minute_pulse_reg <= minute_carry;
			if (read && !ack_reg) begin
				readdata_reg <= {24'h0, rd_byte};
			end
		end
	end

	assign waitrequest = !ack_reg;
	assign readdata    = readdata_reg;
	assign minute_tick = minute_pulse_reg;

	a_minutes_range: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R01)
		!$past(wr_any) |-> (time_reg.minutes[7] == 1'b0 && time_reg.minutes <= 8'h59 || $past(time_reg.minutes) > 8'h59))
		else $error("minutes left range");
	a_minute_wrap: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R01)
		(minute_carry && time_reg.minutes == 8'h59 && !wr_min) |=> time_reg.minutes == 8'h00)
		else $error("minutes did not wrap");
	a_hour24_wrap: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R03)
		(minute_carry && time_reg.minutes == 8'h59 && time_reg.hours == 8'h23 && !wr_any) |=>
		(time_reg.hours == 8'h00 && time_reg.day != $past(time_reg.day)))
		else $error("24-hour rollover wrong");
	a_hour12_pm: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R02)
		(minute_carry && time_reg.minutes == 8'h59 && time_reg.hours == 8'h51 && !wr_any) |=> time_reg.hours == 8'h72)
		else $error("12-hour noon flip wrong");
	a_hour12_wrap: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R02)
		(minute_carry && time_reg.minutes == 8'h59 && time_reg.hours == 8'h52 && !wr_any) |=> time_reg.hours == 8'h41)
		else $error("12 to 1 wrong");
	a_feb_leap: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R05)
		(u_next.day_roll && minute_carry && time_reg.month == 8'h02 && time_reg.day == 8'h28 && !wr_any) |=>
		(time_reg.day == ((year_reg[1:0] == 2'b00 && !year_reg[4] || year_reg[4] && year_reg[1:0] == 2'b10) ? 8'h29 : 8'h01)))
		else $error("february leap handling wrong");
	a_weekday_cycle: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R06)
		(u_next.day_roll && minute_carry && time_reg.weekday == 8'h07 && !wr_any) |=> time_reg.weekday == 8'h01)
		else $error("weekday did not cycle");
	a_month_wrap: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R07)
		(u_next.mon_roll && minute_carry && time_reg.month == 8'h12 && !wr_any) |=> time_reg.month == 8'h01)
		else $error("december did not wrap");
	a_unused_zero: assert property (@(posedge clock) disable iff (!rst_n_reg) // see (R08)
		ack_reg && $past(read) |-> readdata[31:8] == 24'h0 &&
		($past(address) != OFS_WEEKDAY || readdata[7:3] == 5'h0))
		else $error("unused bits not zero");
endmodule : rtccal_top

// ==== rtccal_host.sv ====
// host model: avalon-mm master for the calendar time registers
`timescale 1ns/100ps
module rtccal_host (
	input  wire logic        clock,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	output logic [3:0]       address,
	output logic             read,
	output logic             write,
	output logic [31:0]      writedata,
	output logic [3:0]       byteenable
);
	initial begin
		address    = 4'h0;
		read       = 1'b0;
		write      = 1'b0;
		writedata  = 32'h0;
		byteenable = 4'h0;
	end

	// callers may hand raw bytes with unimplemented bits set, which the masks clear; weekday meaning is theirs
	task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clock);
		address    <= a;
		read       <= ~wr;
		write      <= wr;
		writedata  <= {24'h0, d};
		byteenable <= be;
		// held until waitrequest is sampled low at a rising edge
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask : access
endmodule : rtccal_host

// ==== test_rtccal_top.sv ====
// self-checking bench for the calendar time registers
`timescale 1ns/100ps
module test_rtccal_top;
	import rtccal_pkg::*;
	logic        clock;
	logic        reset_n;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        minute_tick;
	logic [31:0] rd;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	rtccal_top #(.SECOND_CYCLES(4)) i_dut (.clock(clock), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .minute_tick(minute_tick));
	rtccal_host i_host (.clock(clock), .readdata(readdata), .waitrequest(waitrequest),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_host.access(1'b1, a, d, 4'h1, rd);
	endtask : wr

	task automatic rc(input string name, input logic [3:0] a, input logic [7:0] exp);
		i_host.access(1'b0, a, 8'h00, 4'h1, rd);
		check(name, rd, {24'h0, exp});
	endtask : rc

	// loads a time one second before the minute carry and waits for it
	task automatic carry(input logic [7:0] mi, hr, dy, wd, mo, yr);
		int n;
		n = 0;
		wr(OFS_SECOND_TICK, 8'h00);
		wr(OFS_MINUTES, mi);
		wr(OFS_HOURS, hr);
		wr(OFS_DAY, dy);
		wr(OFS_WEEKDAY, wd);
		wr(OFS_MONTH, mo);
		wr(OFS_YEAR, yr);
		wr(OFS_SECOND_TICK, 8'h59);
		while (minute_tick !== 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		check("minute_tick", {31'h0, minute_tick}, 32'h1);
	endtask : carry

	task automatic t_reset();
		rc("min_rst", OFS_MINUTES, RST_MINUTES);
		rc("hour_rst", OFS_HOURS, RST_HOURS);
		rc("day_rst", OFS_DAY, RST_DAY);
		rc("wday_rst", OFS_WEEKDAY, RST_WEEKDAY);
		rc("mon_rst", OFS_MONTH, RST_MONTH);
		wr(4'h5, 8'ha5);
		rc("unmapped", 4'h5, 8'h00);
	endtask : t_reset

	task automatic t_fields();
		wr(OFS_MINUTES, 8'hd9);
		rc("min_bits", OFS_MINUTES, 8'h59);
		wr(OFS_HOURS, 8'ha3);
		rc("hour_bits", OFS_HOURS, 8'h23);
		wr(OFS_DAY, 8'hc5);
		rc("day_bits", OFS_DAY, 8'h05);
		wr(OFS_WEEKDAY, 8'hfb);
		rc("wday_bits", OFS_WEEKDAY, 8'h03);
		wr(OFS_MONTH, 8'he9);
		rc("mon_bits", OFS_MONTH, 8'h09);
		i_host.access(1'b1, OFS_MINUTES, 8'h33, 4'he, rd);
		rc("lane_off", OFS_MINUTES, 8'h59);
	endtask : t_fields

	task automatic t_roll();
		carry(8'h09, 8'h05, 8'h10, 8'h03, 8'h05, 8'h04);
		rc("min_bcd", OFS_MINUTES, 8'h10);
		carry(8'h59, 8'h23, 8'h31, 8'h07, 8'h12, 8'h04);
		rc("min_wrap", OFS_MINUTES, 8'h00);
		rc("hour_wrap", OFS_HOURS, 8'h00);
		rc("day_wrap", OFS_DAY, 8'h01);
		rc("wday_wrap", OFS_WEEKDAY, 8'h01);
		rc("mon_wrap", OFS_MONTH, 8'h01);
		carry(8'h59, 8'h23, 8'h30, 8'h02, 8'h04, 8'h04);
		rc("apr_day", OFS_DAY, 8'h01);
		rc("apr_end", OFS_MONTH, 8'h05);
	endtask : t_roll

	task automatic t_12h();
		carry(8'h59, 8'h51, 8'h10, 8'h02, 8'h05, 8'h04);
		rc("noon", OFS_HOURS, 8'h72);
		carry(8'h59, 8'h52, 8'h10, 8'h02, 8'h05, 8'h04);
		rc("one_am", OFS_HOURS, 8'h41);
		carry(8'h59, 8'h71, 8'h10, 8'h02, 8'h05, 8'h04);
		rc("midnight", OFS_HOURS, 8'h52);
		rc("day_12h", OFS_DAY, 8'h11);
	endtask : t_12h

	task automatic t_leap();
		carry(8'h59, 8'h23, 8'h28, 8'h02, 8'h02, 8'h04);
		rc("feb_leap", OFS_DAY, 8'h29);
		carry(8'h59, 8'h23, 8'h29, 8'h02, 8'h02, 8'h04);
		rc("feb_end", OFS_MONTH, 8'h03);
		carry(8'h59, 8'h23, 8'h28, 8'h02, 8'h02, 8'h00);
		rc("year_zero", OFS_DAY, 8'h29);
		carry(8'h59, 8'h23, 8'h28, 8'h02, 8'h02, 8'h12);
		rc("odd_tens_leap", OFS_DAY, 8'h29);
		carry(8'h59, 8'h23, 8'h28, 8'h02, 8'h02, 8'h10);
		rc("odd_tens_plain", OFS_DAY, 8'h01);
		carry(8'h59, 8'h23, 8'h28, 8'h02, 8'h02, 8'h03);
		rc("feb_plain", OFS_DAY, 8'h01);
		rc("mar_plain", OFS_MONTH, 8'h03);
	endtask : t_leap

	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			fail_count++;
			stop_test();
		end
	end

	initial begin
		reset_n = 1'b0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_fields();
		t_roll();
		t_12h();
		t_leap();
		stop_test();
	end
endmodule : test_rtccal_top
